// ---- smc_controller.sv ----
// standby mode controller: halt/stop sequencing and clock gating
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/100ps
module smc_controller #(
    parameter int STOP_WAIT = smc_pkg::STOP_WAIT_CYC
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic HALT_EXEC,
    input wire logic STOP_EXEC,
    input wire logic IRQ_UNMASKED,
    input wire logic INTERRUPT_ENABLE_FLAG,
    input wire logic LS_STOPPABLE_OPT,
    input wire logic [7:0] LOWSPEED_OSC_MODE_REG,
    input wire logic WDT_CLK_IS_LS,
    input wire logic TMR_CLK_IS_LS,
    output logic CPU_CLK_EN,
    output logic SYS_OSC_EN,
    output logic PERIPH_CLK_EN,
    output logic LS_OSC_EN,
    output logic WDT_CLK_EN,
    output logic TMR_CLK_EN,
    output logic STATE_HOLD,
    output logic OPT_REFERENCE,
    output logic WAKE_VECTOR,
    output logic WAKE_NEXT,
    output logic IN_HALT,
    output logic IN_STOP
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // one packed record so the whole state registers together
    typedef struct packed {
        smc_pkg::smc_state_type st;
        logic vec;
        logic ls_on;
        logic [smc_pkg::CNT_W-1:0] cnt;
        logic [7:0] lsmode;
    } smc_ctl_type;
    smc_ctl_type s_reg, s_next;

    // wake delay handshake
    logic dly_load;
    logic [smc_pkg::CNT_W-1:0] dly_value;
    logic dly_done;
    logic ls_req;

    // ----------------------------------------------------------------
    // low-speed oscillator
    // ----------------------------------------------------------------
    // stop bit only counts when the option permits software stop
    // limitation: the option is a level taken as static after reset
    assign ls_req = !(LS_STOPPABLE_OPT
        && s_reg.lsmode[smc_pkg::LSOSC_STOP_BIT]);

    // ----------------------------------------------------------------
    // wake delay
    // ----------------------------------------------------------------
    // one shared counter: halt and stop waits can never overlap
    smc_delay #(
        .W(smc_pkg::CNT_W)
    ) u_delay (
        .clk(MCLK),
        .rst(RST),
        .load(dly_load),
        .value(dly_value),
        .done(dly_done)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        // wake delay idle unless a wake is taken this cycle
        dly_load = 1'b0;
        dly_value = '0;
        // mode register write is frozen in stop so a running osc stays on
        if (s_reg.st != smc_pkg::ST_STOP
            && s_reg.st != smc_pkg::ST_STOP_WAIT) begin
            s_next.lsmode = LOWSPEED_OSC_MODE_REG;
        end
        if (s_reg.st == smc_pkg::ST_RESET) begin
            s_next.ls_on = 1'b0;
        end else if (s_reg.st == smc_pkg::ST_STOP
            || s_reg.st == smc_pkg::ST_STOP_WAIT) begin
            // a running oscillator may not be stopped while in stop
            s_next.ls_on = s_reg.ls_on;
        end else begin
            s_next.ls_on = ls_req;
        end
        case (s_reg.st)
            smc_pkg::ST_RESET: begin
                // OPT_REFERENCE held here for OPT_REF_CYC cycles before the cpu starts
                s_next.cnt = s_reg.cnt + 1'b1;
                if (s_reg.cnt ==
                    smc_pkg::CNT_W'(smc_pkg::OPT_REF_CYC - 1)) begin
                    s_next.st = smc_pkg::ST_RUN;
                    s_next.cnt = '0;
                end
            end
            smc_pkg::ST_RUN: begin
                // exec strobes come at instruction completion
                // a pending request cancels entry instead of a round trip
                if (IRQ_UNMASKED) begin
                    s_next.st = smc_pkg::ST_RUN;
                end else if (HALT_EXEC) begin
                    s_next.st = smc_pkg::ST_HALT;
                end else if (STOP_EXEC) begin
                    s_next.st = smc_pkg::ST_STOP;
                end
            end
            smc_pkg::ST_HALT: begin
                // masked requests leave halt held
                if (IRQ_UNMASKED) begin
                    s_next.vec = INTERRUPT_ENABLE_FLAG;
                    s_next.st = smc_pkg::ST_RESUME;
                    dly_load = 1'b1;
                    dly_value = INTERRUPT_ENABLE_FLAG
                        ? smc_pkg::CNT_W'(smc_pkg::HALT_VEC_CYC - 2)
                        : smc_pkg::CNT_W'(smc_pkg::HALT_NEXT_CYC - 2);
                end
            end
            smc_pkg::ST_STOP: begin
                // fixed typical wait; oscillator settling is not measured
                if (IRQ_UNMASKED) begin
                    s_next.vec = INTERRUPT_ENABLE_FLAG;
                    s_next.st = smc_pkg::ST_STOP_WAIT;
                    dly_load = 1'b1;
                    dly_value = smc_pkg::CNT_W'(STOP_WAIT - 1);
                end
            end
            smc_pkg::ST_STOP_WAIT: begin
                // oscillator back on, cpu still held for the stop time
                if (dly_done) begin
                    s_next.st = smc_pkg::ST_RUN;
                end
            end
            smc_pkg::ST_RESUME: begin
                // halt wake needs no settling, only the restart wait
                if (dly_done) begin
                    s_next.st = smc_pkg::ST_RUN;
                end
            end
            // unreachable encodings fall back to the option phase
            default: s_next.st = smc_pkg::ST_RESET;
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (RST) begin
            // reset wins over any wake request in the same cycle
            s_reg <= '{st: smc_pkg::ST_RESET, vec: 1'b0,
                ls_on: 1'b0, cnt: '0,
                lsmode: smc_pkg::LSMODE_RESET};
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // stop_wait counts as stop: the cpu sees one unbroken standby
    logic halted, stopped, waking;
    assign halted = (s_reg.st == smc_pkg::ST_HALT);
    assign stopped = (s_reg.st == smc_pkg::ST_STOP)
        || (s_reg.st == smc_pkg::ST_STOP_WAIT);
    assign waking = (s_reg.st == smc_pkg::ST_STOP_WAIT)
        || (s_reg.st == smc_pkg::ST_RESUME);

    // ----------------------------------------------------------------
    // clock gates
    // ----------------------------------------------------------------
    assign CPU_CLK_EN = (s_reg.st == smc_pkg::ST_RUN);
    // oscillator also off through the reset and option phase
    assign SYS_OSC_EN = (s_reg.st != smc_pkg::ST_STOP)
        && (s_reg.st != smc_pkg::ST_RESET);
    assign PERIPH_CLK_EN = SYS_OSC_EN && !waking;
    assign LS_OSC_EN = s_reg.ls_on;
    // system-clocked watchdog stops in halt and stop, runs during the wake waits
    assign WDT_CLK_EN = WDT_CLK_IS_LS ? s_reg.ls_on
        : (CPU_CLK_EN || waking);
    // prescaled timer lives on the peripheral clock, so none of it in stop
    assign TMR_CLK_EN = TMR_CLK_IS_LS ? s_reg.ls_on
        : (PERIPH_CLK_EN && !stopped);

    // ----------------------------------------------------------------
    // status and wake strobes
    // ----------------------------------------------------------------
    // cpu keeps registers, memory and port latches while asserted
    assign STATE_HOLD = halted || stopped || waking;
    assign OPT_REFERENCE = (s_reg.st == smc_pkg::ST_RESET);
    // wake strobes last one cycle, on the last cycle of the wait
    assign WAKE_VECTOR = waking && dly_done && s_reg.vec;
    assign WAKE_NEXT = waking && dly_done && !s_reg.vec;
    assign IN_HALT = halted;
    assign IN_STOP = stopped;
endmodule : smc_controller

// ---- smc_controller_chk.sv ----
// port assertions for the standby mode controller
`timescale 1ns/100ps
module smc_chk (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic IRQ_UNMASKED,
    input wire logic INTERRUPT_ENABLE_FLAG,
    input wire logic LS_STOPPABLE_OPT,
    input wire logic CPU_CLK_EN,
    input wire logic SYS_OSC_EN,
    input wire logic PERIPH_CLK_EN,
    input wire logic LS_OSC_EN,
    input wire logic OPT_REFERENCE,
    input wire logic WAKE_VECTOR,
    input wire logic WAKE_NEXT,
    input wire logic IN_HALT,
    input wire logic IN_STOP
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence wake_ie(ie);
        IN_HALT && IRQ_UNMASKED && INTERRUPT_ENABLE_FLAG == ie;
    endsequence
    a_halt_gate: assert property (
        IN_HALT |-> !CPU_CLK_EN && SYS_OSC_EN && PERIPH_CLK_EN)
        else $error("halt clock gating wrong");
    a_stop_osc: assert property (
        IN_STOP && !$past(IRQ_UNMASKED)
        && !($past(IN_STOP) && $past(SYS_OSC_EN))
        |-> !SYS_OSC_EN && !CPU_CLK_EN) else $error("stop osc on");
    a_ls_keep: assert property (
        (IN_HALT || IN_STOP) && $past(IN_HALT || IN_STOP)
        && $past(LS_OSC_EN) |-> LS_OSC_EN) else $error("ls osc lost");
    a_ls_nonstop: assert property (
        !LS_STOPPABLE_OPT && $past(!LS_STOPPABLE_OPT) && !$past(RST)
        && !OPT_REFERENCE && !$past(OPT_REFERENCE)
        |-> LS_OSC_EN) else $error("ls osc stopped");
    a_entry_block: assert property (
        CPU_CLK_EN && IRQ_UNMASKED |=> !IN_HALT && !IN_STOP)
        else $error("entered with pending request");
    a_masked_hold: assert property (
        IN_HALT && !IRQ_UNMASKED |=> IN_HALT) else $error("halt left");
    a_vec_time: assert property (
        wake_ie(1'b1) |-> ##[11:13] WAKE_VECTOR)
        else $error("vector wake time");
    a_next_time: assert property (
        wake_ie(1'b0) |-> ##[3:5] WAKE_NEXT)
        else $error("next wake time");
endmodule : smc_chk
bind smc_controller smc_chk u_chk (.MCLK, .RST, .IRQ_UNMASKED,
    .INTERRUPT_ENABLE_FLAG, .LS_STOPPABLE_OPT, .CPU_CLK_EN, .SYS_OSC_EN,
    .PERIPH_CLK_EN, .LS_OSC_EN, .OPT_REFERENCE, .WAKE_VECTOR, .WAKE_NEXT,
    .IN_HALT, .IN_STOP);

// ---- smc_controller_tb.sv ----
// self-checking bench for the standby mode controller
`timescale 1ns/100ps
module smc_controller_tb;
    logic MCLK = 1'b0, RST = 1'b1, hr, sr, irq, msk, ie, lso, wls, tls;
    logic [7:0] osc_mode;
    logic ce, se, pe, le, we, te, hold, opt, wv, wn, inh, ins, he, xe, iu;
    logic [4:0] ev;
    int fail_count = 0, num_checks = 0, n;
    bit off = 0;
    assign ev = {ce, ins, inh, wn, wv};
    initial forever #5 MCLK = ~MCLK;
    smc_cpu_model cpu (.clk(MCLK), .halt_req(hr), .stop_req(sr),
        .irq_flag(irq), .mask_flag(msk), .halt_exec(he), .stop_exec(xe),
        .irq_unmasked(iu));
    smc_controller #(.STOP_WAIT(5)) dut (.MCLK, .RST, .HALT_EXEC(he),
        .STOP_EXEC(xe), .IRQ_UNMASKED(iu), .INTERRUPT_ENABLE_FLAG(ie),
        .LS_STOPPABLE_OPT(lso), .LOWSPEED_OSC_MODE_REG(osc_mode),
        .WDT_CLK_IS_LS(wls), .TMR_CLK_IS_LS(tls), .CPU_CLK_EN(ce),
        .SYS_OSC_EN(se), .PERIPH_CLK_EN(pe), .LS_OSC_EN(le), .WDT_CLK_EN(we),
        .TMR_CLK_EN(te), .STATE_HOLD(hold), .OPT_REFERENCE(opt),
        .WAKE_VECTOR(wv), .WAKE_NEXT(wn), .IN_HALT(inh), .IN_STOP(ins));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // counts falling edges until the selected event shows
    task automatic wait_on(input int s);
        n = 0;
        do begin
            @(negedge MCLK);
            n++;
        end while (n < 200 && ev[s] !== 1'b1);
        if (n >= 200) begin
            fail_count++;
            report_and_stop();
        end
    endtask : wait_on
    task automatic standby(input bit stp, input bit iev, input int lat);
        @(posedge MCLK);
        {hr, sr, ie} <= {!stp, stp, iev};
        wait_on(stp ? 3 : 2);
        chk({ce, se, pe, hold, le}, {1'b0, !stp, !stp, 1'b1, !off});
        if (!stp) chk({we, te}, {2{!off}});
        @(posedge MCLK);
        {hr, sr, irq} <= 3'b001;
        wait_on(iev ? 0 : 1);
        chk(8'(n), 8'(lat));
        @(posedge MCLK);
        irq <= 1'b0;
        wait_on(4);
        $display("standby stp=%0d ie=%0d done", stp, iev);
    endtask : standby
    initial begin
        {hr, sr, irq, msk, ie, lso, wls, tls} = 8'h03;
        osc_mode = 8'h00;
        repeat (8) @(posedge MCLK);
        RST <= 1'b0;
        @(negedge MCLK);
        chk({opt, ce}, 2'b10);
        wait_on(4);
        standby(0, 1, 12);
        standby(0, 0, 4);
        standby(1, 1, 6);
        standby(1, 0, 6);
        @(posedge MCLK);
        {lso, osc_mode} <= 9'h101;
        off = 1;
        repeat (3) @(negedge MCLK);
        chk(le, 1'b0);
        standby(0, 1, 12);
        @(posedge MCLK);
        lso <= 1'b0;
        off = 0;
        repeat (3) @(negedge MCLK);
        chk(le, 1'b1);
        @(posedge MCLK);
        {hr, irq, msk, wls, tls} <= 5'b11100;
        wait_on(2);
        repeat (20) @(negedge MCLK);
        chk({inh, we, te}, 3'b101);
        @(posedge MCLK);
        {hr, msk, ie} <= 3'b000;
        wait_on(1);
        chk(8'(n), 8'h04);
        @(posedge MCLK);
        hr <= 1'b1;
        repeat (4) @(negedge MCLK);
        chk({inh, ce}, 2'b01);
        @(posedge MCLK);
        {hr, irq} <= 2'b00;
        @(posedge MCLK);
        hr <= 1'b1;
        wait_on(2);
        @(posedge MCLK);
        {hr, irq, RST} <= 3'b011;
        @(posedge MCLK);
        RST <= 1'b0;
        @(negedge MCLK);
        chk({inh, wv, wn, opt}, 4'b0001);
        $display("mode tests done");
        report_and_stop();
    end
endmodule : smc_controller_tb

// ---- smc_cpu_model.sv ----
// cpu core and interrupt flag model facing the standby controller
`timescale 1ns/100ps
module smc_cpu_model (
    input wire logic clk,
    input wire logic halt_req,
    input wire logic stop_req,
    input wire logic irq_flag,
    input wire logic mask_flag,
    output logic halt_exec,
    output logic stop_exec,
    output logic irq_unmasked
);
    logic halt_d;
    logic stop_d;
    always_ff @(posedge clk) begin
        halt_d <= halt_req;
        stop_d <= stop_req;
    end
    // one pulse per request; peripherals assumed idle before stop
    assign halt_exec = halt_req && !halt_d;
    assign stop_exec = stop_req && !stop_d;
    assign irq_unmasked = irq_flag && !mask_flag;
endmodule : smc_cpu_model

// ---- smc_delay.sv ----
// down counter that times wake-up waits
`timescale 1ns/100ps
module smc_delay #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic busy;
    } smc_dly_type;
    smc_dly_type s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        if (load) begin
            s_next.cnt = value;
            s_next.busy = 1'b1;
        end else if (s_reg.busy) begin
            if (s_reg.cnt == '0) begin
                s_next.busy = 1'b0;
            end else begin
                s_next.cnt = s_reg.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign done = s_reg.busy && (s_reg.cnt == '0) && !load;
endmodule : smc_delay

// ---- smc_pkg.sv ----
// package of constants and types for the standby mode controller
package smc_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int STOP_MIN_US = 17;
    localparam int STOP_TYP_US = 34;
    localparam int STOP_MAX_US = 67;
    localparam int STOP_WAIT_CYC = STOP_TYP_US * CLK_MHZ;
    localparam int HALT_VEC_CYC = 12;
    localparam int HALT_NEXT_CYC = 4;
    localparam int OPT_REF_CYC = 8;
    localparam int CNT_W = 16;
    localparam int LSOSC_STOP_BIT = 0;
    localparam int TMR_PRE_MAX_LOG2 = 12;
    localparam int TMR_LS_DIV_LOG2 = 7;
    localparam logic [7:0] LSMODE_RESET = 8'h00;

    typedef enum {
        ST_RESET, ST_RUN, ST_HALT, ST_STOP, ST_STOP_WAIT, ST_RESUME
    } smc_state_type;
endpackage : smc_pkg
